// >>> crs_sequencer.sv
// cold and warm reset sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"

module crs_sequencer #(
  parameter int HOLD_CYCLES = `CRS_HOLD_CYCLES,
  parameter int QUIET_CYCLES = `CRS_QUIET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // cold reset from the board, active low, asynchronous
  input wire logic cold_reset_in_b,
  // system reset pin, open drain
  input wire logic system_reset_pin_in,
  output logic system_reset_pin_out,
  output logic system_reset_pin_oe,
  // warm reset sources inside the device
  input wire logic sw_reset_req,
  input wire logic bus_timer_timeout,
  // memory data bus
  input wire logic [`CRS_BUS_W-1:0] memory_data_bus_in,
  output logic memory_data_bus_oe,
  // transceiver and strobes
  output crs_pkg::crs_xcvr_t xcvr,
  output crs_pkg::crs_strobes_t strobes_force,
  // system clock out
  output logic system_clock_out,
  // processor side
  output logic [`CRS_VEC_W-1:0] boot_vector,
  output logic cpu_reset_exc,
  output logic cpu_soft_reset_exc,
  output logic in_reset
);
  localparam int CNT_MAX = (1 << `CRS_CNT_W) - 1;

  // counts must fit the per-state counter, and zero would wrap to a 256-cycle state
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > CNT_MAX ||
      QUIET_CYCLES < 1 || QUIET_CYCLES > CNT_MAX) begin : g_bad_counts
    $error("crs_sequencer: cycle counts must fit the counter");
  end

  localparam logic [`CRS_CNT_W-1:0] HOLD_LAST = `CRS_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [`CRS_CNT_W-1:0] QUIET_LAST = `CRS_CNT_W'(QUIET_CYCLES - 1);
  localparam logic [`CRS_CNT_W-1:0] CNT_ZERO = '0;

  crs_pkg::crs_state_t state_q;
  crs_pkg::crs_state_t state_d;
  logic [`CRS_CNT_W-1:0] cnt_q;
  logic cold_b_s;
  logic pin_s;
  logic warm_req;
  logic pin_armed_q;
  logic [`CRS_VEC_W-1:0] vec_p1_q;
  logic [`CRS_VEC_W-1:0] vec_p2_q;
  logic [`CRS_VEC_W-1:0] vec_p3_q;
  logic [`CRS_VEC_W-1:0] vec_p4_q;
  logic clk_div_q;

  // ************************************************
  // input synchronisers
  // ************************************************
  crs_sync #(.RESET_VAL(1'b0)) u_cold_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(cold_reset_in_b),
    .level_out(cold_b_s)
  );

  // pin is asynchronous, so it is filtered like any pin
  crs_sync #(.RESET_VAL(1'b1)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(system_reset_pin_in),
    .level_out(pin_s)
  );

  // ************************************************
  // sequencer
  // ************************************************
  // pin armed only once seen high after our own drive; the synced level lags the release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_armed_q <= 1'b0;
    end else if (system_reset_pin_oe) begin
      pin_armed_q <= 1'b0;
    end else if (pin_s) begin
      pin_armed_q <= 1'b1;
    end
  end

  // pin only counts in run and when armed; own drive would otherwise retrigger
  assign warm_req = (!pin_s && pin_armed_q) || sw_reset_req || bus_timer_timeout;

  always_comb begin
    state_d = state_q;
    case (state_q)
      crs_pkg::CRS_IDLE: begin
        state_d = crs_pkg::CRS_COLD_SAMPLE;
      end
      crs_pkg::CRS_COLD_SAMPLE: begin
        if (cold_b_s) begin
          state_d = crs_pkg::CRS_COLD_DRIVE;
        end
      end
      crs_pkg::CRS_COLD_DRIVE: begin
        if (cnt_q == HOLD_LAST) begin
          state_d = crs_pkg::CRS_RUN;
        end
      end
      crs_pkg::CRS_RUN: begin
        if (warm_req) begin
          state_d = crs_pkg::CRS_WARM_HOLD;
        end
      end
      crs_pkg::CRS_WARM_HOLD: begin
        if (cnt_q == HOLD_LAST) begin
          state_d = crs_pkg::CRS_WARM_QUIET;
        end
      end
      crs_pkg::CRS_WARM_QUIET: begin
        if (cnt_q == QUIET_LAST) begin
          state_d = crs_pkg::CRS_RUN;
        end
      end
      default: begin
        state_d = crs_pkg::CRS_IDLE;
      end
    endcase
    // cold reset wins from any state
    if (!cold_b_s) begin
      state_d = crs_pkg::CRS_COLD_SAMPLE;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= crs_pkg::CRS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // per-state cycle counter, cleared on each state change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= CNT_ZERO;
    end else if (state_d != state_q) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_q + `CRS_CNT_W'(1);
    end
  end

  // ************************************************
  // boot vector capture
  // ************************************************
  // bus samples ride beside the cold synchroniser, so the value taken is the one
  // seen while the raw cold input was still low, not after the board let go
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_p1_q <= '0;
      vec_p2_q <= '0;
      vec_p3_q <= '0;
      vec_p4_q <= '0;
    end else begin
      vec_p1_q <= memory_data_bus_in[`CRS_VEC_W-1:0];
      vec_p2_q <= vec_p1_q;
      vec_p3_q <= vec_p2_q;
      vec_p4_q <= vec_p3_q;
    end
  end

  // sample while cold reset low; the last value before release stays
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_vector <= '0;
    end else if (state_q == crs_pkg::CRS_COLD_SAMPLE && !cold_b_s) begin
      boot_vector <= vec_p4_q;
    end
  end

  // ************************************************
  // pin and bus controls, registered
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_reset_pin_oe <= 1'b1;
      memory_data_bus_oe <= 1'b0;
      xcvr <= '0;
      strobes_force <= '1;
      in_reset <= 1'b1;
    end else begin
      case (state_d)
        crs_pkg::CRS_IDLE, crs_pkg::CRS_COLD_SAMPLE: begin
          system_reset_pin_oe <= 1'b1;
          memory_data_bus_oe <= 1'b0;
          xcvr <= '0;
          strobes_force <= '1;
          in_reset <= 1'b1;
        end
        crs_pkg::CRS_COLD_DRIVE: begin
          system_reset_pin_oe <= 1'b1;
          memory_data_bus_oe <= 1'b1;
          xcvr <= '1;
          strobes_force <= '1;
          in_reset <= 1'b1;
        end
        crs_pkg::CRS_WARM_HOLD: begin
          system_reset_pin_oe <= 1'b1;
          memory_data_bus_oe <= 1'b0;
          xcvr <= '1;
          strobes_force <= '1;
          in_reset <= 1'b1;
        end
        crs_pkg::CRS_WARM_QUIET: begin
          system_reset_pin_oe <= 1'b0;
          memory_data_bus_oe <= 1'b1;
          xcvr <= '1;
          strobes_force <= '1;
          in_reset <= 1'b1;
        end
        default: begin
          system_reset_pin_oe <= 1'b0;
          memory_data_bus_oe <= 1'b1;
          xcvr <= '1;
          strobes_force <= '0;
          in_reset <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign system_reset_pin_out = 1'b0;

  // one-cycle exception pulses on leaving reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_reset_exc <= 1'b0;
      cpu_soft_reset_exc <= 1'b0;
    end else begin
      cpu_reset_exc <= (state_q == crs_pkg::CRS_COLD_DRIVE) &&
                       (state_d == crs_pkg::CRS_RUN);
      cpu_soft_reset_exc <= (state_q == crs_pkg::CRS_WARM_QUIET) &&
                            (state_d == crs_pkg::CRS_RUN);
    end
  end

  // ************************************************
  // system clock out: clk/2, held low once the option is set
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_div_q <= 1'b0;
    end else if (boot_vector[`CRS_HOLD_CLK_BIT] &&
                 state_q != crs_pkg::CRS_COLD_SAMPLE &&
                 state_q != crs_pkg::CRS_IDLE) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
    end
  end

  assign system_clock_out = clk_div_q;
endmodule
`default_nettype wire

// >>> crs_cfg.svh
// constants for the cold and warm reset sequencer
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
`define CRS_CLK_MHZ 50
`define CRS_VEC_W 16
`define CRS_BUS_W 32
`define CRS_HOLD_CLK_BIT 11
`define CRS_SYNC_STAGES 3
`define CRS_HOLD_CYCLES 4
`define CRS_QUIET_CYCLES 4
`define CRS_CNT_W 8
`define CRS_CLK_DIV_W 1
`endif

// >>> crs_pkg.sv
// types shared by the reset sequencer files
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_IDLE,
    CRS_COLD_SAMPLE,
    CRS_COLD_DRIVE,
    CRS_RUN,
    CRS_WARM_HOLD,
    CRS_WARM_QUIET
  } crs_state_t;

  // memory strobes, all active low
  typedef struct packed {
    logic row_strobe_b;
    logic column_strobe_b;
    logic read_write_select_b;
    logic output_enable_strobe_b;
  } crs_strobes_t;

  // transceiver controls
  typedef struct packed {
    logic transceiver_enable;
    logic transceiver_direction;
  } crs_xcvr_t;
endpackage

// >>> crs_sync.sv
// three-stage synchroniser for a pin input with agreement filter
`timescale 1ns/1ps
`default_nettype none
module crs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin in, filtered level out
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // chain: first stage read by the second only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_out <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule
`default_nettype wire

// >>> crs_board_model.sv
// board model: cold reset, boot vector drive and the pulled-up reset pin wire
`timescale 1ns/1ps
`default_nettype none
module crs_board_model (
  // bench controls
  input wire logic clk,
  input wire logic cold_req,
  input wire logic pull_low,
  input wire logic [15:0] vec,
  // device pins
  input wire logic pin_oe,
  output logic cold_reset_in_b,
  output logic system_reset_pin_in,
  output logic [31:0] memory_data_bus_in
);
  logic [1:0] hold_q = 2'h0;
  logic cold_q = 1'b1;
  logic [31:0] bus_q = 32'h0;
  assign cold_reset_in_b = cold_q;
  assign memory_data_bus_in = bus_q;
  // open-drain wire: either party pulls low, pull-up otherwise
  assign system_reset_pin_in = !(pin_oe || pull_low);
  // vector kept past the cold release, then released lines wander every cycle
  always @(posedge clk) begin
    cold_q <= !cold_req;
    hold_q <= cold_q ? {hold_q[0], 1'b0} : 2'h3;
    if (!cold_q || hold_q != 2'h0)
      bus_q <= {~bus_q[31:16], vec & 16'h3FFF};
    else
      bus_q <= ~bus_q;
  end
endmodule
`default_nettype wire

// >>> crs_sequencer_props.sv
// port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crs_cfg.svh"
module crs_sequencer_props #(
  parameter int HOLD_CYCLES = `CRS_HOLD_CYCLES,
  parameter int QUIET_CYCLES = `CRS_QUIET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // reset sources
  input wire logic cold_reset_in_b,
  input wire logic system_reset_pin_in,
  input wire logic sw_reset_req,
  // watched outputs
  input wire logic system_reset_pin_oe,
  input wire logic memory_data_bus_oe,
  input wire crs_pkg::crs_xcvr_t xcvr,
  input wire crs_pkg::crs_strobes_t strobes_force,
  input wire logic system_clock_out,
  input wire logic [`CRS_VEC_W-1:0] boot_vector,
  input wire logic cpu_reset_exc,
  input wire logic cpu_soft_reset_exc,
  input wire logic in_reset
);
  localparam int HOLD_M1 = HOLD_CYCLES - 1;
  localparam int QUIET_P1 = QUIET_CYCLES + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // warm hold opens on the pin drive, closes with the bus driven again
  sequence s_warm_open;
    $rose(system_reset_pin_oe) && xcvr == 2'b11;
  endsequence
  sequence s_warm_close;
    ##HOLD_M1 system_reset_pin_oe ##1 (!system_reset_pin_oe && memory_data_bus_oe);
  endsequence
  a_cold_drive_low: assert property (
    !cold_reset_in_b [*6] |-> system_reset_pin_oe && !memory_data_bus_oe && xcvr == 2'b00)
    else $error("cold reset outputs wrong");
  a_warm_entry: assert property (
    sw_reset_req && !in_reset && cold_reset_in_b |->
    ##[1:2] (system_reset_pin_oe && in_reset && !memory_data_bus_oe)) else $error("warm entry");
  a_strobes_forced: assert property (
    in_reset |-> strobes_force == 4'hF) else $error("strobes not deasserted");
  // a cold restart cuts the warm hold short, so it is left out here
  a_warm_hold: assert property (
    disable iff (!rst_b || !cold_reset_in_b) s_warm_open |-> s_warm_close)
    else $error("warm hold length");
  a_soft_exc: assert property (
    cpu_soft_reset_exc |-> !in_reset && !$past(system_reset_pin_oe, QUIET_CYCLES) &&
    $past(system_reset_pin_oe, QUIET_P1)) else $error("soft exception timing");
  a_cold_exc: assert property (
    cpu_reset_exc |-> !system_reset_pin_oe && memory_data_bus_oe && xcvr == 2'b11)
    else $error("cold end outputs");
  a_vec_kept: assert property (
    xcvr == 2'b11 ##1 xcvr == 2'b11 |-> $stable(boot_vector)) else $error("vector changed");
  a_clk_held: assert property (
    (boot_vector[11] && xcvr == 2'b11) [*2] |-> !system_clock_out) else $error("clock not held");
  a_clk_toggle: assert property (
    (!boot_vector[11] && xcvr == 2'b11) [*2] |-> system_clock_out != $past(system_clock_out))
    else $error("clock not toggling");
  a_pin_synced: assert property (
    !in_reset && !system_reset_pin_oe && $fell(system_reset_pin_in) |=> !system_reset_pin_oe)
    else $error("pin taken unsynchronised");
endmodule
bind crs_sequencer crs_sequencer_props #(.HOLD_CYCLES(HOLD_CYCLES), .QUIET_CYCLES(QUIET_CYCLES))
  u_crs_sequencer_props (.clk, .rst_b, .cold_reset_in_b, .system_reset_pin_in, .sw_reset_req,
  .system_reset_pin_oe, .memory_data_bus_oe, .xcvr, .strobes_force, .system_clock_out,
  .boot_vector, .cpu_reset_exc, .cpu_soft_reset_exc, .in_reset);
`default_nettype wire

// >>> crs_sequencer_tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_tb;
  localparam int HOLD = 4;
  localparam int QUIET = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cold_req = 1'b1;
  logic pull_low = 1'b0;
  logic sw_reset_req = 1'b0;
  logic bus_timer_timeout = 1'b0;
  logic [15:0] vec = 16'h0000;
  logic cold_reset_in_b, system_reset_pin_in, system_reset_pin_out, system_reset_pin_oe;
  logic memory_data_bus_oe, system_clock_out, cpu_reset_exc, cpu_soft_reset_exc, in_reset;
  logic [31:0] memory_data_bus_in;
  logic [15:0] boot_vector, n;
  crs_pkg::crs_xcvr_t xcvr;
  crs_pkg::crs_strobes_t strobes_force;
  int mismatches = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  crs_sequencer #(.HOLD_CYCLES(HOLD), .QUIET_CYCLES(QUIET)) u_crs_sequencer (.clk, .rst_b,
    .cold_reset_in_b, .system_reset_pin_in, .system_reset_pin_out, .system_reset_pin_oe,
    .sw_reset_req, .bus_timer_timeout, .memory_data_bus_in, .memory_data_bus_oe, .xcvr,
    .strobes_force, .system_clock_out, .boot_vector, .cpu_reset_exc, .cpu_soft_reset_exc,
    .in_reset);
  crs_board_model u_crs_board_model (.clk, .cold_req, .pull_low, .vec,
    .pin_oe(system_reset_pin_oe), .cold_reset_in_b, .system_reset_pin_in, .memory_data_bus_in);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // cold reset with a given vector, then the clock-out behaviour it selects
  task automatic t_cold(input logic [15:0] v);
    logic b;
    vec = v;
    cold_req = 1'b1;
    tick(8);
    chk({14'h0, system_reset_pin_oe, memory_data_bus_oe}, 16'h2, "cold pin/bus");
    chk({14'h0, xcvr}, 16'h0, "cold xcvr");
    cold_req = 1'b0;
    for (n = 0; n < 16'd40 && cpu_reset_exc !== 1'b1; n++) tick(1);
    chk({15'h0, cpu_reset_exc}, 16'h1, "no reset exception");
    chk(boot_vector, v & 16'h3FFF, "boot vector");
    chk({13'h0, xcvr, memory_data_bus_oe}, 16'h7, "bus after cold");
    n = 0;
    for (int i = 0; i < 4; i++) begin
      b = system_clock_out;
      tick(1);
      n = n + {15'h0, system_clock_out !== b};
    end
    chk(n, v[11] ? 16'h0 : 16'h4, "clock out");
    $display("cold test done");
  endtask
  // warm reset from software, bus timer or pin; hold and quiet lengths
  task automatic t_warm(input int src);
    sw_reset_req = (src == 0);
    bus_timer_timeout = (src == 1);
    pull_low = (src == 2);
    tick(1);
    sw_reset_req = 1'b0;
    bus_timer_timeout = 1'b0;
    if (src == 2) chk({15'h0, system_reset_pin_oe}, 16'h0, "pin too fast");
    for (n = 0; n < 16'd10 && system_reset_pin_oe !== 1'b1; n++) tick(1);
    pull_low = 1'b0;
    chk({11'h0, strobes_force, memory_data_bus_oe}, 16'h1E, "warm bus");
    chk({15'h0, system_reset_pin_out}, 16'h0, "pin drive not low");
    for (n = 0; n < 16'd20 && system_reset_pin_oe === 1'b1; n++) tick(1);
    chk(n, 16'(HOLD), "hold length");
    chk({15'h0, memory_data_bus_oe}, 16'h1, "bus after pin release");
    for (n = 0; n < 16'd20 && cpu_soft_reset_exc !== 1'b1; n++) tick(1);
    chk(n, 16'(QUIET), "quiet length");
    chk({11'h0, strobes_force, in_reset}, 16'h0, "warm end");
    $display("warm test %0d done", src);
  endtask
  initial begin
    tick(6);
    rst_b = 1'b1;
    t_cold(16'hCA5A);
    for (int s = 0; s < 3; s++) t_warm(s);
    t_cold(16'h1234);
    t_warm(2);
    sw_reset_req = 1'b1;
    tick(1);
    sw_reset_req = 1'b0;
    t_cold(16'h0123);
    test_done;
  end
  // the sequence takes about 120 cycles; this allows far more
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
